// ### verilog/pml_lane_mac.sv
// Functional notes
// - Invert request flips PHY receive decoder polarity
// - Training state as 5-bit code
// - Everything timed by the PIPE clock
// - Rate input 00/01/1x gives three generations
// - Block start marks first word at gen3
// - Compliance forces negative disparity comma
// - 32-bit transmit word per lane
// - Control flags tag bytes, low first, gen1/2
// - Skip flag: 1 valid, 0 ignore, gen3
// - De-emphasis taken from partner during training
// - Detect request starts receiver detection
// - Idle force puts transmitter in idle
// - Margin comes from link control field
// - Swing high full, low half
// - Sync header 01 ordered set, 10 data
// - Rate output 00/01/10, 11 reserved
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pml_params.svh"

module pml_lane_mac
    import pml_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_rx_invert_request,
    input wire logic [2:0] i_rx_phy_status_code,
    input wire logic i_rx_lock_valid,
    input wire logic i_partner_deemph,
    output logic [4:0] o_link_training_state_code,
    input wire logic [1:0] i_sim_rate,
    output logic [1:0] o_rate,
    output logic o_tx_block_start,
    output logic o_tx_negative_disparity_force,
    output logic [31:0] o_tx_lane_word,
    output logic [3:0] o_tx_control_byte_flags,
    output logic o_tx_word_valid_skip,
    output logic o_tx_deemphasis_select,
    output logic o_tx_receiver_detect_request,
    output logic o_tx_idle_force,
    output logic [2:0] o_tx_voltage_margin,
    output logic o_tx_full_swing,
    output logic [1:0] o_tx_block_type_header
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [6:0] txctl_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    pml_state_t state_q;
    pml_state_t state_d;
    logic [2:0] rxst_q;
    logic rxvld_q;
    logic deemph_q;
    logic [1:0] rate_q;
    logic [4:0] code_q;
    logic inv_q;
    logic idle_q;
    logic compl_q;
    logic det_q;
    logic [2:0] margin_q;
    logic swing_q;
    logic [31:0] word_q;
    logic [3:0] flags_q;
    logic skip_q;
    logic blkst_q;
    logic [1:0] synchd_q;

    pml_fifo_if #(.W(`PML_FIFO_W)) push_if ();
    pml_fifo_if #(.W(`PML_FIFO_W)) pop_if ();

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    wire wr_ctrl_a = (i_awaddr == `PML_OFS_CTRL);
    wire wr_txctl_a = (i_awaddr == `PML_OFS_TXCTL);
    wire wr_data_a = (i_awaddr == `PML_OFS_TXDATA);
    wire wr_known = wr_ctrl_a || wr_txctl_a || wr_data_a;
    wire wr_go = i_awvalid && i_wvalid && !bvalid_q && (!wr_data_a || push_if.ready);
    wire wr_lo = i_wstrb[0];
    wire rd_go = i_arvalid && !rvalid_q;
    wire rd_ctrl_a = (i_araddr == `PML_OFS_CTRL);
    wire rd_txctl_a = (i_araddr == `PML_OFS_TXCTL);
    wire rd_stat_a = (i_araddr == `PML_OFS_STATUS);
    wire rd_data_a = (i_araddr == `PML_OFS_TXDATA);
    wire rd_known = rd_ctrl_a || rd_txctl_a || rd_stat_a || rd_data_a;

    wire [31:0] stat_word = {19'h0, push_if.ready, deemph_q, o_rate, code_q, rxvld_q, rxst_q};
    wire [31:0] rd_mux = rd_ctrl_a ? {24'h0, ctrl_q} :
                         rd_txctl_a ? {25'h0, txctl_q} :
                         rd_stat_a ? stat_word : 32'h0;

    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = rd_go;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = rdata_q;

    // Transmit words enter the queue tagged with the current control fields
    assign push_if.valid = wr_go && wr_data_a;
    assign push_if.data = {txctl_q, i_wdata};

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    wire ctl_inv = ctrl_q[`PML_CTRL_INV];
    wire ctl_idle = ctrl_q[`PML_CTRL_IDLE];
    wire ctl_compl = ctrl_q[`PML_CTRL_COMPL];
    wire ctl_train = ctrl_q[`PML_CTRL_TRAIN];
    wire ctl_swing = ctrl_q[`PML_CTRL_SWING];
    wire [2:0] ctl_margin = ctrl_q[`PML_CTRL_MARGIN_LO +: 3];

    // ------------------------------------------------------------
    // Rate decode
    // ------------------------------------------------------------
    wire in_g3 = pml_is_gen3(i_sim_rate);
    wire [1:0] rate_d = in_g3 ? `PML_RATE_G3 : i_sim_rate;
    wire out_g3 = pml_is_gen3(rate_q);

    // ------------------------------------------------------------
    // Transmit drain
    // ------------------------------------------------------------
    wire drain_en = !ctl_idle && (state_q != PML_ST_QUIET);
    wire pop = pop_if.valid && drain_en;
    assign pop_if.ready = drain_en;
    wire [31:0] pop_word = pop_if.data[31:0];
    wire [3:0] pop_flags = pop_if.data[35:32];
    wire [1:0] pop_sh = pop_if.data[37:36];
    wire pop_blk = pop_if.data[38];

    // ------------------------------------------------------------
    // Training state machine
    // ------------------------------------------------------------
    wire detected = (rxst_q == `PML_RXST_DETECTED);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            PML_ST_QUIET:
            begin
                if (ctl_train && detected)
                begin
                    state_d = PML_ST_POLL_ACT;
                end
            end
            PML_ST_POLL_ACT:
            begin
                if (!ctl_train)
                begin
                    state_d = PML_ST_QUIET;
                end
                else if (ctl_compl)
                begin
                    state_d = PML_ST_POLL_COMPL;
                end
            end
            PML_ST_POLL_COMPL:
            begin
                if (!ctl_train)
                begin
                    state_d = PML_ST_QUIET;
                end
                else if (!ctl_compl)
                begin
                    state_d = PML_ST_POLL_ACT;
                end
            end
        endcase
    end

    wire [4:0] code_d = (state_q == PML_ST_POLL_ACT) ? `PML_LT_POLL_ACT :
                        (state_q == PML_ST_POLL_COMPL) ? `PML_LT_POLL_COMPL :
                        `PML_LT_QUIET;

    // Partner de-emphasis captured while locked in active polling (PML_ST_POLL_ACT only)
    wire deemph_take = (state_q == PML_ST_POLL_ACT) && rxvld_q;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_q <= `PML_CTRL_RST;
            txctl_q <= `PML_TXCTL_RST;
            bvalid_q <= 1'b0;
            bresp_q <= `PML_RESP_OK;
            rvalid_q <= 1'b0;
            rresp_q <= `PML_RESP_OK;
            rdata_q <= 32'h0;
        end
        else
        begin
            if (wr_go && wr_ctrl_a && wr_lo)
            begin
                ctrl_q <= i_wdata[7:0];
            end
            if (wr_go && wr_txctl_a && wr_lo)
            begin
                txctl_q <= i_wdata[6:0];
            end
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_known ? `PML_RESP_OK : `PML_RESP_SLVERR;
            end
            else if (i_bready)
            begin
                bvalid_q <= 1'b0;
            end
            if (rd_go)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_known ? `PML_RESP_OK : `PML_RESP_SLVERR;
            end
            else if (i_rready)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Input sampling and state
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rxst_q <= 3'h0;
            rxvld_q <= 1'b0;
            state_q <= PML_ST_QUIET;
            deemph_q <= 1'b0;
            rate_q <= `PML_RATE_G1;
            code_q <= `PML_LT_QUIET;
        end
        else
        begin
            rxst_q <= i_rx_phy_status_code;
            rxvld_q <= i_rx_lock_valid;
            state_q <= state_d;
            code_q <= code_d;
            rate_q <= rate_d;
            if (deemph_take)
            begin
                deemph_q <= i_partner_deemph;
            end
        end
    end

    // ------------------------------------------------------------
    // Lane control outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            inv_q <= 1'b0;
            idle_q <= 1'b1;
            compl_q <= 1'b0;
            det_q <= 1'b0;
            margin_q <= 3'h0;
            swing_q <= 1'b1;
        end
        else
        begin
            inv_q <= ctl_inv;
            idle_q <= ctl_idle || (state_q == PML_ST_QUIET);
            compl_q <= (state_q == PML_ST_POLL_COMPL);
            det_q <= ctl_train && (state_q == PML_ST_QUIET);
            margin_q <= ctl_margin;
            swing_q <= ctl_swing;
        end
    end

    // ------------------------------------------------------------
    // Transmit data outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            word_q <= 32'h0;
            flags_q <= 4'h0;
            skip_q <= 1'b0;
            blkst_q <= 1'b0;
            synchd_q <= `PML_SH_DATA;
        end
        else
        begin
            word_q <= pop ? pop_word : 32'h0;
            flags_q <= (pop && !in_g3) ? pop_flags : 4'h0;
            skip_q <= pop && in_g3;
            blkst_q <= pop && in_g3 && pop_blk;
            if (pop && in_g3)
            begin
                synchd_q <= pop_sh;
            end
        end
    end

    assign o_rx_invert_request = inv_q;
    assign o_link_training_state_code = code_q;
    assign o_rate = rate_q;
    assign o_tx_block_start = blkst_q;
    assign o_tx_negative_disparity_force = compl_q;
    assign o_tx_lane_word = word_q;
    assign o_tx_control_byte_flags = flags_q;
    assign o_tx_word_valid_skip = skip_q;
    assign o_tx_deemphasis_select = deemph_q;
    assign o_tx_receiver_detect_request = det_q;
    assign o_tx_idle_force = idle_q;
    assign o_tx_voltage_margin = margin_q;
    assign o_tx_full_swing = swing_q;
    assign o_tx_block_type_header = synchd_q;

    // ------------------------------------------------------------
    // Queue
    // ------------------------------------------------------------
    pml_fifo #(
        .W(`PML_FIFO_W),
        .D(`PML_FIFO_D)
    ) u_txq (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_push(push_if),
        .o_pop(pop_if)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    sequence s_detect;
        o_tx_receiver_detect_request && ctl_train && detected;
    endsequence

    sequence s_pop_g3;
        pop && in_g3;
    endsequence

    AST_RX_INVERT: assert property (ctl_inv ##1 ctl_inv |-> o_rx_invert_request)
        else $error("Invert request not following control");
    AST_CODE_LEGAL: assert property (o_link_training_state_code inside
        {`PML_LT_QUIET, `PML_LT_POLL_ACT, `PML_LT_POLL_COMPL})
        else $error("Illegal training state code");
    AST_RATE_G3: assert property (i_sim_rate[1] |=> o_rate == `PML_RATE_G3)
        else $error("Gen3 rate not decoded");
    AST_RATE_LOW: assert property (!i_sim_rate[1] |=> o_rate == $past(i_sim_rate))
        else $error("Low rate not passed through");
    AST_BLKST: assert property (o_tx_block_start |-> o_tx_word_valid_skip && out_g3)
        else $error("Block start outside a gen3 word");
    AST_COMPL: assert property (state_q == PML_ST_POLL_COMPL |=> o_tx_negative_disparity_force)
        else $error("Compliance without disparity force");
    AST_WORD: assert property (pop |=> o_tx_lane_word == $past(pop_word))
        else $error("Transmit word mismatch");
    AST_FLAGS_G3: assert property (o_tx_word_valid_skip |-> o_tx_control_byte_flags == 4'h0)
        else $error("Control flags driven at gen3");
    AST_SKIP: assert property (s_pop_g3 |=> o_tx_word_valid_skip)
        else $error("Valid gen3 word not flagged");
    AST_DETECT: assert property (s_detect |-> ##2 o_link_training_state_code == `PML_LT_POLL_ACT)
        else $error("Detection did not reach polling");
    AST_IDLE: assert property (ctl_idle |=> o_tx_idle_force && !o_tx_word_valid_skip)
        else $error("Idle force not applied");

endmodule : pml_lane_mac

`default_nettype wire

// ### verilog/pml_params.svh
`ifndef PML_PARAMS_SVH
`define PML_PARAMS_SVH

// Register byte offsets
`define PML_OFS_CTRL 32'h0000_0000
`define PML_OFS_TXCTL 32'h0000_0004
`define PML_OFS_TXDATA 32'h0000_0008
`define PML_OFS_STATUS 32'h0000_000c

// Control register fields
`define PML_CTRL_INV 0
`define PML_CTRL_IDLE 1
`define PML_CTRL_COMPL 2
`define PML_CTRL_TRAIN 3
`define PML_CTRL_SWING 4
`define PML_CTRL_MARGIN_LO 5
`define PML_CTRL_RST 8'h12
`define PML_TXCTL_RST 7'h00

// Link training state codes
`define PML_LT_QUIET 5'h00
`define PML_LT_POLL_ACT 5'h01
`define PML_LT_POLL_COMPL 5'h03

// Rate codes and block headers
`define PML_RATE_G1 2'h0
`define PML_RATE_G2 2'h1
`define PML_RATE_G3 2'h2
`define PML_SH_OS 2'h1
`define PML_SH_DATA 2'h2

// Status code reported when a receiver is detected
`define PML_RXST_DETECTED 3'h3

// Transmit queue shape
`define PML_FIFO_W 39
`define PML_FIFO_D 32

// AXI responses
`define PML_RESP_OK 2'h0
`define PML_RESP_SLVERR 2'h2

`endif

// ### verilog/pml_pkg.sv
package pml_pkg;

    typedef enum logic [1:0] {
        PML_ST_QUIET,
        PML_ST_POLL_ACT,
        PML_ST_POLL_COMPL
    } pml_state_t;

    typedef logic [1:0] pml_rate_t;

    // Third generation when the upper rate bit is set
    function automatic logic pml_is_gen3(input pml_rate_t r);
        pml_is_gen3 = r[1];
    endfunction : pml_is_gen3

endpackage : pml_pkg

// ### verilog/pml_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none

interface pml_fifo_if #(
    parameter int W = 39
);
    logic [W-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : pml_fifo_if

`default_nettype wire

// ### verilog/pml_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module pml_fifo #(
    parameter int W = 39,
    parameter int D = 32
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    pml_fifo_if.snk i_push,
    pml_fifo_if.src o_pop
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] cnt_q;
    logic [W-1:0] out_q;
    logic out_vld_q;

    wire push = i_push.valid && i_push.ready;
    wire pop = out_vld_q && o_pop.ready;
    wire load = (cnt_q != '0) && (!out_vld_q || pop);
    // Registered head counts toward the depth
    wire [AW:0] fill = cnt_q + (AW+1)'(out_vld_q);

    assign i_push.ready = (fill != D[AW:0]);
    assign o_pop.valid = out_vld_q;
    assign o_pop.data = out_q;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= i_push.data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and registered head
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
            out_q <= '0;
            out_vld_q <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
                out_q <= mem[rd_ptr_q];
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
            if (load)
            begin
                out_vld_q <= 1'b1;
            end
            else if (pop)
            begin
                out_vld_q <= 1'b0;
            end
        end
    end

    AST_FIFO_NO_OVER: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        cnt_q <= D[AW:0])
        else $error("Queue count beyond depth");

endmodule : pml_fifo

`default_nettype wire

// ### verification/pml_phy_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Lane transceiver model
// ----------------------------------------
module pml_phy_model #(
    parameter int DLY = 4,
    parameter logic DEEMPH = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_detect,
    output logic [2:0] o_status,
    output logic o_lock_valid,
    output logic o_deemph
);
    int cnt;

    // Everything moves on the lane clock edge
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cnt <= 0;
            o_status <= 3'h0;
            o_lock_valid <= 1'b0;
            o_deemph <= ~DEEMPH;
        end
        else
        begin
            o_status <= 3'h0;
            cnt <= i_detect ? cnt + 1 : 0;
            if (i_detect && cnt == DLY)
                o_status <= 3'h3;
            if (o_status == 3'h3)
                o_lock_valid <= 1'b1;
            else if (i_detect && cnt == 0)
                o_lock_valid <= 1'b0;
            o_deemph <= o_lock_valid ? DEEMPH : ~o_deemph;
        end
    end
endmodule : pml_phy_model

`default_nettype wire

// ### verification/pipe_mac_phy_lane_interface_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "pml_params.svh"

module pipe_mac_phy_lane_interface_bench;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    logic [1:0] i_sim_rate = 2'h0;
    logic [2:0] i_rx_phy_status_code;
    logic i_rx_lock_valid, i_partner_deemph;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rx_invert_request;
    logic o_tx_block_start, o_tx_negative_disparity_force, o_tx_word_valid_skip;
    logic o_tx_deemphasis_select, o_tx_receiver_detect_request, o_tx_idle_force;
    logic o_tx_full_swing;
    logic [1:0] o_bresp, o_rresp, o_rate, o_tx_block_type_header;
    logic [31:0] o_rdata, o_tx_lane_word, rdat;
    logic [4:0] o_link_training_state_code;
    logic [3:0] o_tx_control_byte_flags;
    logic [2:0] o_tx_voltage_margin;
    logic [1:0] rsp;
    int num_errors = 0;
    int n_compared = 0;
    int k;

    always #25 i_mclk = ~i_mclk;

    pml_lane_mac u_dut (
        .i_mclk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_rx_invert_request,
        .i_rx_phy_status_code, .i_rx_lock_valid, .i_partner_deemph,
        .o_link_training_state_code, .i_sim_rate, .o_rate, .o_tx_block_start,
        .o_tx_negative_disparity_force, .o_tx_lane_word, .o_tx_control_byte_flags,
        .o_tx_word_valid_skip, .o_tx_deemphasis_select, .o_tx_receiver_detect_request,
        .o_tx_idle_force, .o_tx_voltage_margin, .o_tx_full_swing, .o_tx_block_type_header
    );

    pml_phy_model #(.DLY(5)) u_phy (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_detect(o_tx_receiver_detect_request),
        .o_status(i_rx_phy_status_code), .o_lock_valid(i_rx_lock_valid),
        .o_deemph(i_partner_deemph)
    );

    // ----------------------------------------
    // Compare, bus and wait tasks
    // ----------------------------------------
    task automatic close_out;
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do @(negedge i_mclk); while (o_awready !== 1'b1 && n++ < 500);
        @(posedge i_mclk);
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        do @(negedge i_mclk); while (o_bvalid !== 1'b1 && n++ < 500);
        rsp = o_bresp;
        @(posedge i_mclk);
        i_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(negedge i_mclk); while (o_arready !== 1'b1 && n++ < 500);
        @(posedge i_mclk);
        i_arvalid <= 1'b0;
        do @(negedge i_mclk); while (o_rvalid !== 1'b1 && n++ < 500);
        d = o_rdata;
        rsp = o_rresp;
        @(posedge i_mclk);
        i_rready <= 1'b0;
    endtask : axi_rd

    function automatic logic cond(input int c);
        case (c)
            0: cond = o_tx_receiver_detect_request;
            1: cond = o_link_training_state_code === 5'h01;
            2: cond = o_link_training_state_code === 5'h03;
            3: cond = o_tx_lane_word !== 32'h0;
            4: cond = o_tx_word_valid_skip;
            5: cond = o_tx_negative_disparity_force;
            default: cond = o_link_training_state_code === 5'h00;
        endcase
    endfunction : cond

    task automatic wait_on(input int c);
        int n;
        n = 0;
        while (cond(c) !== 1'b1 && n++ < 200) @(negedge i_mclk);
        chk(cond(c), 1'b1);
    endtask : wait_on

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge i_mclk);
        chk(o_tx_idle_force, 1'b1);
        chk(o_tx_full_swing, 1'b1);
        chk(o_link_training_state_code, 5'h00);
        i_rstn <= 1'b1;
        axi_rd(`PML_OFS_CTRL, rdat);
        chk(rdat, 32'h12);
        axi_rd(32'h10, rdat);
        chk(rsp, 2'h2);
        for (k = 0; k < 4; k++)
        begin
            @(posedge i_mclk);
            i_sim_rate <= k[1:0];
            repeat (3) @(negedge i_mclk);
            chk(o_rate, k[1] ? 32'h2 : k);
        end
        @(posedge i_mclk);
        i_sim_rate <= 2'h0;
        axi_wr(`PML_OFS_CTRL, 32'ha1);
        chk(rsp, 2'h0);
        repeat (3) @(negedge i_mclk);
        chk(o_rx_invert_request, 1'b1);
        chk(o_tx_voltage_margin, 3'h5);
        chk(o_tx_full_swing, 1'b0);
        chk(o_tx_idle_force, 1'b1);
        axi_wr(`PML_OFS_CTRL, 32'h18);
        wait_on(0);
        wait_on(1);
        repeat (4) @(negedge i_mclk);
        chk(o_tx_deemphasis_select, 1'b1);
        chk(o_tx_idle_force, 1'b0);
        axi_rd(`PML_OFS_STATUS, rdat);
        chk(rdat[8:4], 5'h01);
        axi_wr(`PML_OFS_TXCTL, 32'h05);
        axi_wr(`PML_OFS_TXDATA, 32'ha5c3_0f01);
        wait_on(3);
        chk(o_tx_lane_word, 32'ha5c3_0f01);
        chk(o_tx_control_byte_flags, 4'h5);
        chk(o_tx_word_valid_skip, 1'b0);
        @(posedge i_mclk);
        i_sim_rate <= 2'h2;
        axi_wr(`PML_OFS_TXCTL, 32'h5f);
        axi_wr(`PML_OFS_TXDATA, 32'h1234_5678);
        wait_on(4);
        chk(o_tx_lane_word, 32'h1234_5678);
        chk(o_tx_block_type_header, 2'h1);
        chk(o_tx_block_start, 1'b1);
        chk(o_tx_control_byte_flags, 4'h0);
        axi_wr(`PML_OFS_TXCTL, 32'h20);
        axi_wr(`PML_OFS_TXDATA, 32'hdead_beef);
        wait_on(4);
        chk(o_tx_block_type_header, 2'h2);
        chk(o_tx_block_start, 1'b0);
        axi_wr(`PML_OFS_CTRL, 32'h1a);
        for (k = 1; k <= 32; k++)
            axi_wr(`PML_OFS_TXDATA, k);
        chk(o_tx_idle_force, 1'b1);
        axi_rd(`PML_OFS_STATUS, rdat);
        chk(rdat[12], 1'b0);
        axi_wr(`PML_OFS_CTRL, 32'h18);
        k = 1;
        repeat (60)
        begin
            @(negedge i_mclk);
            if (o_tx_word_valid_skip === 1'b1)
            begin
                chk(o_tx_lane_word, k);
                k++;
            end
        end
        chk(k, 33);
        axi_rd(`PML_OFS_STATUS, rdat);
        chk(rdat[12], 1'b1);
        axi_wr(`PML_OFS_CTRL, 32'h1c);
        wait_on(2);
        wait_on(5);
        axi_wr(`PML_OFS_CTRL, 32'h10);
        wait_on(6);
        close_out;
    end

    initial
    begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        close_out;
    end
endmodule : pipe_mac_phy_lane_interface_bench

`default_nettype wire
